// File: src/rpsc_pkg.sv
// Constants and types for the reset and power-saving controller
package rpsc_pkg;
    localparam int unsigned CLK_FREQ_HZ    = 125_000_000;
    localparam int unsigned XTAL_FREQ_HZ   = 12_000_000;
    // Reset recognition: 24 crystal clocks, converted to ref_clk cycles (least time, round up)
    localparam int unsigned RST_XTAL_CLKS  = 24;
    localparam int unsigned RST_FILT_CYC   = (RST_XTAL_CLKS * (CLK_FREQ_HZ / 1000) + (XTAL_FREQ_HZ / 1000) - 1)
                                             / (XTAL_FREQ_HZ / 1000);
    localparam int unsigned RST_HOLD_CYC   = 2048;
    // Oscillator restart after power-down, several milliseconds
    localparam int unsigned OSC_STAB_MS    = 5;
    localparam int unsigned OSC_STAB_CYC   = OSC_STAB_MS * (CLK_FREQ_HZ / 1000);
    localparam int unsigned CNT_W          = 24;
    localparam logic [15:0] RESET_PC       = 16'h0000;

    typedef enum {
        RPSC_RUN,
        RPSC_IDLE,
        RPSC_PDOWN,
        RPSC_OSC_WAIT
    } rpsc_state_t;
endpackage : rpsc_pkg

// File: src/rpsc_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module rpsc_sync (
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    input  wire logic din,
    output logic      dout
);
    logic [2:0] sh_ff;
    logic [2:0] nxt_sh;
    logic       out_ff;
    logic       nxt_out;

    always_comb begin
        nxt_sh  = {sh_ff[1:0], din};
        // First stage feeds only the second; change counts when stages 2 and 3 agree
        nxt_out = (sh_ff[1] == sh_ff[2]) ? sh_ff[2] : out_ff;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sh_ff  <= 3'h0;
            out_ff <= 1'b0;
        end else begin
            sh_ff  <= nxt_sh;
            out_ff <= nxt_out;
        end
    end
    assign dout = out_ff;
endmodule : rpsc_sync
`default_nettype wire

// File: src/rpsc_timer.sv
// Loadable down-counter flagging expiry
`timescale 1ns/100ps
`default_nettype none
module rpsc_timer (
    input  wire logic                     ref_clk,
    input  wire logic                     sys_rst,
    input  wire logic                     load,
    input  wire logic [rpsc_pkg::CNT_W-1:0] value,
    output logic                          busy
);
    import rpsc_pkg::*;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;

    always_comb begin
        nxt_cnt = cnt_ff;
        if (load) begin
            nxt_cnt = value;
        end else if (cnt_ff != '0) begin
            nxt_cnt = cnt_ff - 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end
    assign busy = (cnt_ff != '0);
endmodule : rpsc_timer
`default_nettype wire

// File: src/rpsc_top.sv
// Reset combiner, reset stretcher and power-saving clock gate control
`timescale 1ns/100ps
`default_nettype none
module rpsc_top #(
    parameter int unsigned OSC_STAB_CYCLES = rpsc_pkg::OSC_STAB_CYC
) (
    input  wire logic        ref_clk,
    input  wire logic        sys_rst,
    input  wire logic        reset_pin,
    input  wire logic        reset_pin_n,
    input  wire logic        standby_en,
    input  wire logic        idle_request_set,
    input  wire logic        powerdown_request_set,
    input  wire logic        irq_pending,
    input  wire logic        slow_analog_converter_irq,
    output logic             int_reset,
    output logic [15:0]      reset_pc,
    output logic             idle_request,
    output logic             powerdown_request,
    output logic             osc_enable,
    output logic             clk_en_cpu,
    output logic             clk_en_acq,
    output logic             clk_en_disp,
    output logic             clk_en_periph,
    output logic             cpu_freeze,
    output logic             display_mem_valid
);
    import rpsc_pkg::*;

    localparam logic [CNT_W-1:0] FILT_LOAD = CNT_W'(RST_FILT_CYC);
    // One short: the edge that raises the internal reset is already the first held cycle
    localparam logic [CNT_W-1:0] HOLD_LOAD = CNT_W'(RST_HOLD_CYC - 1);

    logic rst_hi_s;
    logic rst_lo_s;
    logic rst_any;

    rpsc_sync u_sync_hi (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .din     (reset_pin),
        .dout    (rst_hi_s)
    );
    rpsc_sync u_sync_lo (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .din     (~reset_pin_n),
        .dout    (rst_lo_s)
    );

    assign rst_any = rst_hi_s | rst_lo_s;

    // Filter counts only while the oscillator runs; in power-down the pin wakes the oscillator first
    logic             osc_run;
    logic [CNT_W-1:0] filt_ff;
    logic [CNT_W-1:0] nxt_filt;
    logic             det_ff;
    logic             nxt_det;
    logic             fire;

    always_comb begin
        nxt_filt = filt_ff;
        nxt_det  = det_ff;
        fire     = 1'b0;
        if (!rst_any || !osc_run) begin
            nxt_filt = '0;
            nxt_det  = 1'b0;
        end else if (!det_ff) begin
            if (filt_ff == FILT_LOAD - 1'b1) begin
                fire    = 1'b1;
                nxt_det = 1'b1;
            end else begin
                nxt_filt = filt_ff + 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            filt_ff <= '0;
            det_ff  <= 1'b0;
        end else begin
            filt_ff <= nxt_filt;
            det_ff  <= nxt_det;
        end
    end

    // Internal reset stretch
    logic hold_busy;
    rpsc_timer u_hold (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .load    (fire),
        .value   (HOLD_LOAD),
        .busy    (hold_busy)
    );

    logic ireset_ff;
    logic nxt_ireset;
    always_comb begin
        nxt_ireset = fire | (hold_busy & (ireset_ff | fire));
    end

    // Oscillator stabilisation timer for power-down exit
    logic             stab_load;
    logic             stab_busy;
    logic [CNT_W-1:0] stab_value;
    assign stab_value = CNT_W'(OSC_STAB_CYCLES);

    rpsc_timer u_stab (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .load    (stab_load),
        .value   (stab_value),
        .busy    (stab_busy)
    );

    // Power mode state machine
    rpsc_state_t st_ff;
    rpsc_state_t nxt_st;
    logic        idle_req_ff;
    logic        nxt_idle_req;
    logic        pdown_req_ff;
    logic        nxt_pdown_req;
    logic        dmem_ff;
    logic        nxt_dmem;
    logic        wake;

    assign wake    = irq_pending | slow_analog_converter_irq;
    // A reset pin held in power-down only restarts the oscillator; it is counted once clocks run
    assign osc_run = (st_ff != RPSC_PDOWN) && (st_ff != RPSC_OSC_WAIT);

    always_comb begin
        nxt_st    = st_ff;
        nxt_idle_req  = idle_req_ff;
        nxt_pdown_req = pdown_req_ff;
        nxt_dmem  = dmem_ff;
        stab_load = 1'b0;
        if (fire || ireset_ff) begin
            // Hardware reset aborts any mode and restores display memory
            nxt_st   = RPSC_RUN;
            nxt_idle_req  = 1'b0;
            nxt_pdown_req = 1'b0;
            nxt_dmem = 1'b1;
        end else begin
            case (st_ff)
                RPSC_RUN: begin
                    if (powerdown_request_set) begin
                        nxt_pdown_req = 1'b1;
                        nxt_st        = RPSC_PDOWN;
                    end else if (idle_request_set) begin
                        nxt_idle_req = 1'b1;
                        nxt_st       = RPSC_IDLE;
                    end
                end
                RPSC_IDLE: begin
                    if (wake) begin
                        nxt_idle_req = 1'b0;
                        nxt_st  = RPSC_RUN;
                    end
                end
                RPSC_PDOWN: begin
                    nxt_dmem = 1'b0;
                    if (wake || rst_any) begin
                        nxt_pdown_req = 1'b0;
                        stab_load = 1'b1;
                        nxt_st    = RPSC_OSC_WAIT;
                    end
                end
                RPSC_OSC_WAIT: begin
                    if (!stab_busy && !stab_load) begin
                        nxt_st = RPSC_RUN;
                    end
                end
                default: begin
                    nxt_st = RPSC_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            st_ff     <= RPSC_RUN;
            idle_req_ff  <= 1'b0;
            pdown_req_ff <= 1'b0;
            dmem_ff   <= 1'b1;
            ireset_ff <= 1'b0;
        end else begin
            st_ff     <= nxt_st;
            idle_req_ff  <= nxt_idle_req;
            pdown_req_ff <= nxt_pdown_req;
            dmem_ff   <= nxt_dmem;
            ireset_ff <= nxt_ireset;
        end
    end

    // Clock gate outputs, registered
    logic osc_ff;
    logic cpu_ff;
    logic acq_ff;
    logic disp_ff;
    logic per_ff;
    logic nxt_osc;
    logic nxt_cpu;
    logic nxt_av;
    logic nxt_per;

    always_comb begin
        nxt_osc = (nxt_st != RPSC_PDOWN);
        nxt_per = (nxt_st == RPSC_RUN) || (nxt_st == RPSC_IDLE);
        nxt_cpu = (nxt_st == RPSC_RUN);
        // Standby keeps acquisition and display off across any wake
        nxt_av  = (nxt_st == RPSC_RUN) && !standby_en;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            osc_ff  <= 1'b1;
            cpu_ff  <= 1'b1;
            acq_ff  <= 1'b1;
            disp_ff <= 1'b1;
            per_ff  <= 1'b1;
        end else begin
            osc_ff  <= nxt_osc;
            cpu_ff  <= nxt_cpu;
            acq_ff  <= nxt_av;
            disp_ff <= nxt_av;
            per_ff  <= nxt_per;
        end
    end

    assign int_reset         = ireset_ff;
    assign reset_pc          = RESET_PC;
    assign idle_request      = idle_req_ff;
    assign powerdown_request = pdown_req_ff;
    assign osc_enable        = osc_ff;
    assign clk_en_cpu        = cpu_ff;
    assign clk_en_acq        = acq_ff;
    assign clk_en_disp       = disp_ff;
    assign clk_en_periph     = per_ff;
    assign cpu_freeze        = ~cpu_ff;
    assign display_mem_valid = dmem_ff;

    // Each pin alone must advance the recognition count
    chk_rst_either: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (rst_hi_s ^ rst_lo_s) && osc_run && !det_ff && (filt_ff != FILT_LOAD - 1'b1)
        |=> filt_ff == $past(filt_ff) + 1'b1)
        else $error("single reset pin not counted");
    chk_filt_len: assert property (@(posedge ref_clk) disable iff (sys_rst)
        fire |-> $past(rst_any, 3) && rst_any)
        else $error("reset recognised too early");
    chk_hold_len: assert property (@(posedge ref_clk) disable iff (sys_rst)
        $rose(ireset_ff) |-> ireset_ff [*8])
        else $error("internal reset too short");
    chk_idle_gate: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (st_ff == RPSC_IDLE) |-> !cpu_ff && !acq_ff && !disp_ff && per_ff && osc_ff)
        else $error("wrong clock gating in idle");
    chk_idle_wake: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (st_ff == RPSC_IDLE) && wake && !fire && !ireset_ff |=> !idle_req_ff ##1 cpu_ff)
        else $error("idle not left on interrupt");
    chk_pdown_osc: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (st_ff == RPSC_PDOWN) |-> !osc_ff && !cpu_ff && !acq_ff && !disp_ff && !per_ff)
        else $error("clock running in power-down");
    chk_pdown_wait: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (st_ff == RPSC_OSC_WAIT) |-> osc_ff && !per_ff && !cpu_ff && !acq_ff && !disp_ff)
        else $error("clocks released before stabilisation");
    chk_stby_av: assert property (@(posedge ref_clk) disable iff (sys_rst)
        standby_en && $past(standby_en) && !$past(sys_rst) |-> !acq_ff && !disp_ff)
        else $error("display clock running in standby");
    chk_rst_abort: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ireset_ff |=> (st_ff == RPSC_RUN) && !idle_req_ff && !pdown_req_ff && dmem_ff)
        else $error("reset did not restore run mode");
    chk_pdown_dmem: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (st_ff == RPSC_PDOWN) |=> !dmem_ff)
        else $error("display memory still valid after power-down");
    chk_stab_start: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (st_ff == RPSC_PDOWN) && (wake || rst_any) |=> (st_ff == RPSC_OSC_WAIT) && stab_busy)
        else $error("power-down exit skipped stabilisation");
endmodule : rpsc_top
`default_nettype wire

// File: tb/rpsc_partner.sv
// Model of the external reset network driving both reset pads
`timescale 1ns/100ps
`default_nettype none
module rpsc_partner #(
    parameter int unsigned POR_CYCLES = 400
) (
    input  wire logic ref_clk,
    input  wire logic push_hi,
    input  wire logic push_lo,
    output logic      reset_pin,
    output logic      reset_pin_n
);
    int unsigned por_cnt = 0;

    // Power-up hold outlasts oscillator settling; afterwards pads rest at their pull levels
    always_ff @(posedge ref_clk) begin
        if (por_cnt < POR_CYCLES) begin
            por_cnt <= por_cnt + 1;
        end
    end
    assign reset_pin   = push_hi | (por_cnt < POR_CYCLES);
    assign reset_pin_n = ~push_lo;
endmodule : rpsc_partner
`default_nettype wire

// File: tb/test_rpsc_top.sv
// Self-checking bench for the reset and power-saving controller
`timescale 1ns/100ps
`default_nettype none
module test_rpsc_top;
    import rpsc_pkg::*;
    localparam int unsigned STAB = 20;
    logic        ref_clk, sys_rst, push_hi, push_lo, reset_pin, reset_pin_n, standby_en;
    logic        idle_request_set, powerdown_request_set, irq_pending, slow_analog_converter_irq;
    logic        int_reset, idle_request, powerdown_request, osc_enable, clk_en_cpu, clk_en_acq;
    logic        clk_en_disp, clk_en_periph, cpu_freeze, display_mem_valid;
    logic [15:0] reset_pc;
    logic [31:0] seed = 32'h8c6e79a6;
    int          fails = 0;
    int          num_checks = 0;
    int          lat, wid, n;
    logic [31:0] r;

    rpsc_partner i_rpsc_partner (.ref_clk(ref_clk), .push_hi(push_hi), .push_lo(push_lo),
        .reset_pin(reset_pin), .reset_pin_n(reset_pin_n));
    rpsc_top #(.OSC_STAB_CYCLES(STAB)) i_rpsc_top (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .reset_pin(reset_pin), .reset_pin_n(reset_pin_n), .standby_en(standby_en),
        .idle_request_set(idle_request_set), .powerdown_request_set(powerdown_request_set),
        .irq_pending(irq_pending), .slow_analog_converter_irq(slow_analog_converter_irq),
        .int_reset(int_reset),
        .reset_pc(reset_pc), .idle_request(idle_request), .powerdown_request(powerdown_request),
        .osc_enable(osc_enable), .clk_en_cpu(clk_en_cpu), .clk_en_acq(clk_en_acq),
        .clk_en_disp(clk_en_disp), .clk_en_periph(clk_en_periph), .cpu_freeze(cpu_freeze),
        .display_mem_valid(display_mem_valid));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic rnd();
        seed = lfsr(seed);
        r = seed;
    endtask : rnd
    task automatic step(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask : step
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic results();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : results
    // Mode bit writes: 0 idle, 1 power-down, 2 both in one cycle; watchdog and display taken as off
    task automatic pulse(input int which);
        idle_request_set = (which != 1);
        powerdown_request_set = (which != 0);
        step(1);
        idle_request_set = 1'b0;
        powerdown_request_set = 1'b0;
    endtask : pulse
    // Latency to internal reset, then its width; a power-down write is tried while it is active
    task automatic meas_reset();
        lat = 0;
        while (int_reset !== 1'b1 && lat < 600) begin
            step(1);
            lat++;
        end
        push_hi = 1'b0;
        push_lo = 1'b0;
        pulse(1);
        wid = 1;
        while (int_reset === 1'b1 && wid < 3000) begin
            step(1);
            wid++;
        end
    endtask : meas_reset
    function automatic logic [5:0] clks();
        return {osc_enable, clk_en_cpu, clk_en_acq, clk_en_disp, clk_en_periph, cpu_freeze};
    endfunction : clks
    // Expected enables: m 0 run, 1 idle, 2 power-down
    function automatic logic [5:0] exp_clks(input int m, input logic sb);
        logic c, v;
        c = (m == 0);
        v = c & ~sb;
        return (m == 2) ? 6'h01 : {1'b1, c, v, v, 1'b1, ~c};
    endfunction : exp_clks

    initial begin
        #200000;
        fails++;
        results();
    end

    initial begin
        sys_rst = 1'b1;
        {push_hi, push_lo, standby_en, idle_request_set, powerdown_request_set} = 5'h00;
        {irq_pending, slow_analog_converter_irq} = 2'h0;
        step(5);
        chk({6'h00, int_reset, idle_request, powerdown_request, display_mem_valid, clks()},
            {6'h00, 4'h1, exp_clks(0, 1'b0)});
        chk(reset_pc, RESET_PC);
        sys_rst = 1'b0;
        meas_reset();
        chk(16'(wid), 16'(RST_HOLD_CYC));
        // Glitches shorter than the recognition time must not reset
        for (int k = 0; k < 4; k++) begin
            rnd();
            push_hi = k[0];
            push_lo = ~k[0];
            step(20 + int'(r % 200));
            {push_hi, push_lo} = 2'h0;
            step(10);
            chk(int_reset, 1'b0);
        end
        for (int k = 0; k < 2; k++) begin
            push_hi = (k == 0);
            push_lo = (k == 1);
            meas_reset();
            chk(lat >= RST_FILT_CYC && lat <= RST_FILT_CYC + 8, 1'b1);
            chk(16'(wid), 16'(RST_HOLD_CYC));
            chk({powerdown_request, clks()}, {1'b0, exp_clks(0, 1'b0)});
        end
        for (int sb = 0; sb < 2; sb++) begin
            for (int src = 0; src < 2; src++) begin
                standby_en = sb[0];
                step(3);
                chk(clks(), exp_clks(0, sb[0]));
                pulse(0);
                rnd();
                step(2 + int'(r % 8));
                chk({idle_request, clks()}, {1'b1, exp_clks(1, sb[0])});
                irq_pending = (src == 0);
                slow_analog_converter_irq = (src == 1);
                step(3);
                chk({idle_request, clks()}, {1'b0, exp_clks(0, sb[0])});
                {irq_pending, slow_analog_converter_irq} = 2'h0;
                step(1);
            end
        end
        // Second pass writes idle and power-down together; power-down must win
        for (int src = 0; src < 2; src++) begin
            standby_en = src[0];
            pulse(src == 0 ? 1 : 2);
            rnd();
            step(2 + int'(r % 10));
            chk({idle_request, powerdown_request, display_mem_valid, clks()},
                {3'h2, exp_clks(2, 1'b0)});
            irq_pending = (src == 0);
            slow_analog_converter_irq = (src == 1);
            n = 0;
            while (clk_en_cpu !== 1'b1 && n < 200) begin
                step(1);
                n++;
            end
            chk(n >= STAB && n <= STAB + 6, 1'b1);
            step(1);
            chk({powerdown_request, clks()}, {1'b0, exp_clks(0, src[0])});
            {irq_pending, slow_analog_converter_irq} = 2'h0;
            step(1);
        end
        standby_en = 1'b0;
        pulse(0);
        step(2);
        push_lo = 1'b1;
        meas_reset();
        chk(lat >= RST_FILT_CYC && lat <= RST_FILT_CYC + 8, 1'b1);
        step(2);
        chk({idle_request, display_mem_valid, clks(), reset_pc[7:0]},
            {2'h1, exp_clks(0, 1'b0), RESET_PC[7:0]});
        // Reset held in power-down waits for the restarted oscillator before it is counted
        pulse(1);
        step(3);
        push_hi = 1'b1;
        meas_reset();
        chk(lat >= STAB + RST_FILT_CYC && lat <= STAB + RST_FILT_CYC + 12, 1'b1);
        chk({powerdown_request, display_mem_valid, clks()}, {2'h1, exp_clks(0, 1'b0)});
        results();
    end
endmodule : test_rpsc_top
`default_nettype wire
